// File: hw/dspf_power_fault.sv
`timescale 1ns/1ps
module dspf_power_fault
    import dspf_pkg::*;
#(
    parameter int CNT_W = LIMIT_CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // supply lockout status, high when above threshold
    input wire logic supply_ok_5v,
    input wire logic supply_ok_3v3,
    input wire logic supply_ok_12v,
    input wire logic supply_ok_m12v,
    input wire logic standby_supply_ok,
    // slot a enables and fault sensing
    input wire logic main_enable_slot_a,
    input wire logic aux_enable_slot_a,
    input wire logic overcurrent_slot_a,
    input wire logic thermal_slot_a,
    input wire logic current_limit_slot_a,
    input wire logic aux_fault_slot_a,
    input wire logic [CNT_W-1:0] limit_timer_cap_slot_a,
    // slot b enables and fault sensing
    input wire logic main_enable_slot_b,
    input wire logic aux_enable_slot_b,
    input wire logic overcurrent_slot_b,
    input wire logic thermal_slot_b,
    input wire logic current_limit_slot_b,
    input wire logic aux_fault_slot_b,
    input wire logic [CNT_W-1:0] limit_timer_cap_slot_b,
    // status write-one-to-clear port
    input wire logic status_wr,
    input wire logic [STATUS_W-1:0] status_wdata,
    // address select and general inputs
    input wire logic addr_sel_2,
    input wire logic addr_sel_1,
    input wire logic addr_sel_0,
    input wire logic gen_input_a,
    input wire logic gen_input_b,
    // slot a outputs
    output logic gate_drive_5v_slot_a,
    output logic gate_drive_3v3_slot_a,
    output logic main_12v_on_slot_a,
    output logic aux_output_slot_a,
    output logic fault_n_slot_a_o,
    output logic fault_n_slot_a_oe,
    // slot b outputs
    output logic gate_drive_5v_slot_b,
    output logic gate_drive_3v3_slot_b,
    output logic main_12v_on_slot_b,
    output logic aux_output_slot_b,
    output logic fault_n_slot_b_o,
    output logic fault_n_slot_b_oe,
    // shared status
    output logic int_n_o,
    output logic int_n_oe,
    output logic [STATUS_W-1:0] status,
    output logic [1:0] common_status,
    output logic [2:0] smbus_base_addr
);
    logic supplies_ok;
    logic [SLOTS-1:0] men, aen, oc, th, lim, axf;
    logic [CNT_W-1:0] cap [SLOTS];
    logic [SLOTS-1:0] men_prev_r, aen_prev_r;
    logic [SLOTS-1:0] main_flt_r, aux_flt_r, aux_on_r;
    logic [SLOTS-1:0] main_trip, aux_trip, lim_trip;
    logic [SLOTS-1:0] gate_r, fault_oe_r;
    logic [STATUS_W-1:0] status_r, status_set;
    logic [1:0] common_r;
    logic [2:0] addr_r;
    logic int_oe_r;
    logic standby_off;

    // the limit timer needs at least two counter bits
    if (CNT_W < 2) begin : g_bad_cnt_w
        $error("dspf_power_fault: CNT_W must be at least 2");
    end

    // gather per-slot pins into vectors so both slots share one code path
    assign men = {main_enable_slot_b, main_enable_slot_a};
    assign aen = {aux_enable_slot_b, aux_enable_slot_a};
    assign oc = {overcurrent_slot_b, overcurrent_slot_a};
    assign th = {thermal_slot_b, thermal_slot_a};
    assign lim = {current_limit_slot_b, current_limit_slot_a};
    assign axf = {aux_fault_slot_b, aux_fault_slot_a};
    assign cap[0] = limit_timer_cap_slot_a;
    assign cap[1] = limit_timer_cap_slot_b;
    assign supplies_ok = supply_ok_5v && supply_ok_3v3 && supply_ok_12v &&
                         supply_ok_m12v;
    // standby-powered logic stays in reset until standby clears lockout
    assign standby_off = rst || !standby_supply_ok;

    // edge detectors follow the pins even in reset, so an enable that is
    // already high at release counts as a level, never as a turn-on edge
    always_ff @(posedge clk) begin
        men_prev_r <= men;
        aen_prev_r <= aen;
    end

    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            dspf_state_t state_r;
            dspf_lim_if #(.CNT_W(CNT_W)) lim_bus ();

            assign lim_bus.in_limit = lim[s] && (state_r == DSPF_ON);
            assign lim_bus.limit_cycles = cap[s];
            assign lim_trip[s] = lim_bus.trip;

            dspf_limit_timer #(.CNT_W(CNT_W)) u_timer (
                .clk(clk),
                .rst(rst),
                .lim(lim_bus.timer)
            );

            // undervoltage while on counts as a fault, like overcurrent
            assign main_trip[s] = (state_r == DSPF_ON) &&
                (oc[s] || th[s] || !supplies_ok || lim_trip[s]);
            assign aux_trip[s] = aux_on_r[s] && axf[s];

            // main output state, each slot on its own copy
            always_ff @(posedge clk) begin
                if (rst) begin
                    state_r <= DSPF_OFF;
                end else begin
                    unique case (state_r)
                        DSPF_OFF: begin
                            // level high alone never turns on
                            if (men[s] && !men_prev_r[s] && supplies_ok &&
                                !main_flt_r[s]) begin
                                state_r <= DSPF_ON;
                            end
                        end
                        DSPF_ON: begin
                            if (main_trip[s]) begin
                                state_r <= DSPF_TRIPPED;
                            end else if (!men[s]) begin
                                state_r <= DSPF_OFF;
                            end
                        end
                        DSPF_TRIPPED: begin
                            if (!men[s]) begin
                                state_r <= DSPF_OFF;
                            end
                        end
                    endcase
                end
            end

            // main fault latch; a new trip wins over a clear
            always_ff @(posedge clk) begin
                if (rst) begin
                    main_flt_r[s] <= 1'b0;
                end else if (main_trip[s]) begin
                    main_flt_r[s] <= 1'b1;
                end else if (!men[s]) begin
                    main_flt_r[s] <= 1'b0;
                end
            end

            // aux output and its fault latch
            always_ff @(posedge clk) begin
                if (rst) begin
                    aux_on_r[s] <= 1'b0;
                    aux_flt_r[s] <= 1'b0;
                end else begin
                    if (aux_trip[s]) begin
                        aux_flt_r[s] <= 1'b1;
                    end else if (!aen[s]) begin
                        aux_flt_r[s] <= 1'b0;
                    end
                    if (aux_trip[s] || !aen[s] || !standby_supply_ok) begin
                        aux_on_r[s] <= 1'b0;
                    end else if (aen[s] && !aen_prev_r[s] &&
                                 !aux_flt_r[s]) begin
                        aux_on_r[s] <= 1'b1;
                    end
                end
            end

            // gate drive and fault line; gates drop one cycle after a trip
            always_ff @(posedge clk) begin
                if (rst) begin
                    gate_r[s] <= 1'b0;
                    fault_oe_r[s] <= 1'b0;
                end else begin
                    gate_r[s] <= (state_r == DSPF_ON) && !main_trip[s] &&
                                 men[s];
                    fault_oe_r[s] <= main_flt_r[s] || aux_flt_r[s] ||
                                     main_trip[s] || aux_trip[s];
                end
            end
        end
    endgenerate

    // events that set status bits
    assign status_set = {aux_trip[1], main_trip[1], aux_trip[0], main_trip[0]};

    // sticky status, write one clears, set wins over clear
    always_ff @(posedge clk) begin
        if (standby_off) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= (status_r & ~(status_wr ? status_wdata : STATUS_RST))
                        | status_set;
        end
    end

    // interrupt follows any set status bit, pulled low while pending
    always_ff @(posedge clk) begin
        if (standby_off) begin
            int_oe_r <= 1'b0;
        end else begin
            int_oe_r <= (|status_set) ||
                (|(status_r & ~(status_wr ? status_wdata : STATUS_RST)));
        end
    end

    // pins are sampled every cycle; pull-ups are outside, open reads high
    always_ff @(posedge clk) begin
        if (standby_off) begin
            addr_r <= ADDR_RST;
            common_r <= COMMON_RST;
        end else begin
            addr_r <= {addr_sel_2, addr_sel_1, addr_sel_0};
            common_r[CS_GEN_A] <= gen_input_a;
            common_r[CS_GEN_B] <= gen_input_b;
        end
    end

    // open-drain data lines only ever drive low
    always_ff @(posedge clk) begin
        fault_n_slot_a_o <= 1'b0;
        fault_n_slot_b_o <= 1'b0;
        int_n_o <= 1'b0;
    end

    // outputs straight from flip-flops
    assign gate_drive_5v_slot_a = gate_r[0];
    assign gate_drive_3v3_slot_a = gate_r[0];
    assign main_12v_on_slot_a = gate_r[0];
    assign aux_output_slot_a = aux_on_r[0];
    assign fault_n_slot_a_oe = fault_oe_r[0];
    assign gate_drive_5v_slot_b = gate_r[1];
    assign gate_drive_3v3_slot_b = gate_r[1];
    assign main_12v_on_slot_b = gate_r[1];
    assign aux_output_slot_b = aux_on_r[1];
    assign fault_n_slot_b_oe = fault_oe_r[1];
    assign int_n_oe = int_oe_r;
    assign status = status_r;
    assign common_status = common_r;
    assign smbus_base_addr = addr_r;
endmodule // dspf_power_fault

// File: hw/dspf_pkg.sv
package dspf_pkg;
    localparam int SLOTS = 2;
    localparam int LIMIT_CNT_W = 16;
    // status register bit positions
    localparam int ST_MAIN_A = 0;
    localparam int ST_AUX_A = 1;
    localparam int ST_MAIN_B = 2;
    localparam int ST_AUX_B = 3;
    localparam int STATUS_W = 4;
    localparam logic [STATUS_W-1:0] STATUS_RST = 4'h0;
    // common status bit positions
    localparam int CS_GEN_A = 0;
    localparam int CS_GEN_B = 1;
    localparam logic [1:0] COMMON_RST = 2'h0;
    // address select reads all-ones when every pin is left open
    localparam logic [2:0] ADDR_RST = 3'h7;
    typedef enum logic [1:0] {
        DSPF_OFF,
        DSPF_ON,
        DSPF_TRIPPED
    } dspf_state_t;
endpackage

// File: hw/dspf_lim_if.sv
`timescale 1ns/1ps
interface dspf_lim_if #(parameter int CNT_W = 16);
    logic in_limit;
    logic [CNT_W-1:0] limit_cycles;
    logic trip;
    modport timer (input in_limit, input limit_cycles, output trip);
    modport user (output in_limit, output limit_cycles, input trip);
endinterface

// File: hw/dspf_limit_timer.sv
`timescale 1ns/1ps
module dspf_limit_timer
    import dspf_pkg::*;
#(
    parameter int CNT_W = LIMIT_CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // limit request and trip
    dspf_lim_if.timer lim
);
    logic [CNT_W-1:0] cnt_r;
    logic trip_r;

    // a one-bit counter cannot tell an idle count from a programmed time
    if (CNT_W < 2) begin : g_bad_cnt_w
        $error("dspf_limit_timer: CNT_W must be at least 2");
    end

    // counts regulation time; leaving limit restarts the filter, so brief
    // inrush pulses never accumulate into a nuisance trip
    always_ff @(posedge clk) begin
        if (rst || !lim.in_limit) begin
            cnt_r <= '0;
        end else if (cnt_r != lim.limit_cycles) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // trip held high once the programmed time is used up, for as long as limiting continues
    always_ff @(posedge clk) begin
        if (rst) begin
            trip_r <= 1'b0;
        end else begin
            trip_r <= lim.in_limit && (cnt_r == lim.limit_cycles);
        end
    end

    assign lim.trip = trip_r;
endmodule // dspf_limit_timer

// File: dv/dspf_power_fault_assertions.sv
`timescale 1ns/1ps
module dspf_power_fault_assertions
    import dspf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched inputs
    input wire logic supply_ok_5v,
    input wire logic standby_supply_ok,
    input wire logic main_enable_slot_a,
    input wire logic aux_enable_slot_a,
    input wire logic overcurrent_slot_a,
    input wire logic status_wr,
    input wire logic addr_sel_2,
    input wire logic addr_sel_1,
    input wire logic addr_sel_0,
    // watched outputs
    input wire logic gate_drive_5v_slot_a,
    input wire logic gate_drive_3v3_slot_a,
    input wire logic main_12v_on_slot_a,
    input wire logic aux_output_slot_a,
    input wire logic fault_n_slot_a_o,
    input wire logic fault_n_slot_a_oe,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    input wire logic [2:0] smbus_base_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // four idle cycles leave room for the latch and then the line to clear
    sequence s_both_low;
        (!main_enable_slot_a && !aux_enable_slot_a) [*4];
    endsequence
    // running slot with steady enable hit by overcurrent
    sequence s_on_fault;
        gate_drive_5v_slot_a && main_enable_slot_a
            && $past(main_enable_slot_a) && overcurrent_slot_a
            && standby_supply_ok && !status_wr;
    endsequence
    property p_gate_off;
        !main_enable_slot_a |-> ##2 !gate_drive_5v_slot_a;
    endproperty
    property p_gate_eq;
        gate_drive_5v_slot_a == gate_drive_3v3_slot_a
            && gate_drive_5v_slot_a == main_12v_on_slot_a;
    endproperty
    property p_trip;
        s_on_fault |=> !gate_drive_5v_slot_a && fault_n_slot_a_oe && int_n_oe;
    endproperty
    property p_uvlo;
        !supply_ok_5v |-> ##2 !gate_drive_5v_slot_a;
    endproperty
    property p_aux_off;
        !aux_enable_slot_a |-> ##1 !aux_output_slot_a;
    endproperty
    property p_hold;
        fault_n_slot_a_oe && main_enable_slot_a && aux_enable_slot_a
            && $past(main_enable_slot_a) && $past(aux_enable_slot_a)
            |=> fault_n_slot_a_oe;
    endproperty
    property p_release;
        s_both_low |-> !fault_n_slot_a_oe;
    endproperty
    property p_open_drain;
        !fault_n_slot_a_o && !int_n_o;
    endproperty
    property p_addr;
        1 |=> smbus_base_addr == ($past(standby_supply_ok) ?
            $past({addr_sel_2, addr_sel_1, addr_sel_0}) : ADDR_RST);
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gates still on after enable low");
    a_gate_eq: assert property (p_gate_eq)
        else $error("gate outputs disagree");
    a_trip: assert property (p_trip)
        else $error("overcurrent did not trip slot");
    a_uvlo: assert property (p_uvlo)
        else $error("gates on under lockout");
    a_aux_off: assert property (p_aux_off)
        else $error("aux on after aux enable low");
    a_hold: assert property (p_hold)
        else $error("fault line released while enabled");
    a_release: assert property (p_release)
        else $error("fault line stuck after both enables low");
    a_open_drain: assert property (p_open_drain)
        else $error("open drain data not low");
    a_addr: assert property (p_addr)
        else $error("base address wrong");
endmodule // dspf_power_fault_assertions

bind dspf_power_fault dspf_power_fault_assertions chk_u (.*);

// File: dv/dspf_slot_src.sv
`timescale 1ns/1ps
module dspf_slot_src (
    // requested enables, bit 0 slot a
    input wire logic [1:0] want_main,
    input wire logic [1:0] want_aux,
    // host owns slot power
    input wire logic smbus_mode,
    // enable pins
    output logic [1:0] main_en,
    output logic [1:0] aux_en
);
    // grounded in host mode so no stray edge can power a slot
    always_comb begin
        main_en = smbus_mode ? 2'h0 : want_main;
        aux_en = smbus_mode ? 2'h0 : want_aux;
    end
endmodule // dspf_slot_src

// File: dv/dual_slot_power_fault_logic_tb.sv
`timescale 1ns/1ps
module dual_slot_power_fault_logic_tb
    import dspf_pkg::*;
;
    logic clk, rst, standby_supply_ok, status_wr, smbus_mode;
    logic supply_ok_5v, supply_ok_3v3, supply_ok_12v, supply_ok_m12v;
    logic main_enable_slot_a, aux_enable_slot_a, main_enable_slot_b;
    logic aux_enable_slot_b, overcurrent_slot_a, thermal_slot_a;
    logic current_limit_slot_a, aux_fault_slot_a, overcurrent_slot_b;
    logic thermal_slot_b, current_limit_slot_b, aux_fault_slot_b;
    logic [LIMIT_CNT_W-1:0] limit_timer_cap_slot_a, limit_timer_cap_slot_b;
    logic [STATUS_W-1:0] status_wdata, status;
    logic [3:0] ok4;
    logic [1:0] want_main, want_aux, men, aen, common_status;
    logic addr_sel_2, addr_sel_1, addr_sel_0, gen_input_a, gen_input_b;
    logic gate_drive_5v_slot_a, gate_drive_3v3_slot_a, main_12v_on_slot_a;
    logic gate_drive_5v_slot_b, gate_drive_3v3_slot_b, main_12v_on_slot_b;
    logic aux_output_slot_a, fault_n_slot_a_o, fault_n_slot_a_oe;
    logic aux_output_slot_b, fault_n_slot_b_o, fault_n_slot_b_oe;
    logic int_n_o, int_n_oe;
    logic [2:0] smbus_base_addr;
    int num_errors = 0, n_tests = 0, seed, rnd, i, cap;
    assign {supply_ok_m12v, supply_ok_12v, supply_ok_3v3, supply_ok_5v} = ok4;
    assign {main_enable_slot_b, main_enable_slot_a} = men;
    assign {aux_enable_slot_b, aux_enable_slot_a} = aen;
    dspf_power_fault dut_u (.*);
    dspf_slot_src src_u (.want_main(want_main), .want_aux(want_aux),
        .smbus_mode(smbus_mode), .main_en(men), .aux_en(aen));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [3:0] g, input logic [3:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one-cycle write pulse, the clear lands on its rising edge, then an idle cycle
    task automatic w1c(input logic [3:0] v);
        status_wr = 1'b1;
        status_wdata = v;
        cyc(1);
        status_wr = 1'b0;
        cyc(1);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // far beyond the two hundred or so cycles the tests need
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        seed = 94044;
        rst = 1'b1;
        ok4 = 4'hf;
        standby_supply_ok = 1'b1;
        {smbus_mode, status_wr, want_main, want_aux, status_wdata} = 0;
        {overcurrent_slot_a, thermal_slot_a, current_limit_slot_a} = 0;
        {aux_fault_slot_a, overcurrent_slot_b, thermal_slot_b} = 0;
        {current_limit_slot_b, aux_fault_slot_b} = 0;
        {addr_sel_2, addr_sel_1, addr_sel_0, gen_input_a, gen_input_b} = 0;
        {limit_timer_cap_slot_a, limit_timer_cap_slot_b} = 0;
        cyc(12);
        rst = 1'b0;
        cyc(2);
        // overcurrent then thermal trip on slot a
        for (i = 0; i < 2; i++) begin
            want_main = 2'h1;
            cyc(3);
            chk(gate_drive_5v_slot_a, 1);
            {thermal_slot_a, overcurrent_slot_a} = i ? 2'h2 : 2'h1;
            cyc(1);
            {thermal_slot_a, overcurrent_slot_a} = 2'h0;
            cyc(2);
            chk(gate_drive_3v3_slot_a, 0);
            chk(fault_n_slot_a_oe, 1);
            chk(int_n_oe, 1);
            chk(status, 4'h1);
            chk(fault_n_slot_b_oe, 0);
            want_main = 2'h0;
            cyc(3);
            chk(fault_n_slot_a_oe, 0);
            w1c(4'h2);
            chk(status, 4'h1);
            w1c(4'h1);
            chk(status, 4'h0);
            chk(int_n_oe, 0);
        end
        $display("test trip done");
        // both faults latched, slot b first and then slot a
        for (i = 0; i < 2; i++) begin
            want_main = i ? 2'h1 : 2'h2;
            want_aux = want_main;
            cyc(3);
            chk(i ? aux_output_slot_a : aux_output_slot_b, 1);
            chk({main_12v_on_slot_b, gate_drive_3v3_slot_b,
                main_12v_on_slot_a, gate_drive_3v3_slot_a},
                i ? 4'h3 : 4'hc);
            chk({fault_n_slot_b_o, fault_n_slot_a_o, int_n_o}, 4'h0);
            {thermal_slot_b, aux_fault_slot_b} = i ? 2'h0 : 2'h3;
            {thermal_slot_a, aux_fault_slot_a} = i ? 2'h3 : 2'h0;
            cyc(1);
            {thermal_slot_b, aux_fault_slot_b, thermal_slot_a} = 3'h0;
            aux_fault_slot_a = 1'b0;
            cyc(2);
            chk(status, i ? 4'h3 : 4'hc);
            want_main = 2'h0;
            cyc(3);
            chk(i ? fault_n_slot_a_oe : fault_n_slot_b_oe, 1);
            want_aux = 2'h0;
            cyc(3);
            chk(i ? fault_n_slot_a_oe : fault_n_slot_b_oe, 0);
            w1c(i ? 4'h3 : 4'hc);
        end
        $display("test dual done");
        // current limit filter, one cycle short and then long enough
        rnd = $random(seed);
        cap = 4 + rnd[3:0];
        limit_timer_cap_slot_a = cap[LIMIT_CNT_W-1:0];
        want_main = 2'h1;
        cyc(3);
        current_limit_slot_a = 1'b1;
        cyc(cap);
        current_limit_slot_a = 1'b0;
        cyc(2);
        current_limit_slot_a = 1'b1;
        cyc(cap);
        chk(gate_drive_5v_slot_a, 1);
        cyc(4);
        chk(gate_drive_5v_slot_a, 0);
        {current_limit_slot_a, want_main} = 0;
        cyc(3);
        w1c(4'h1);
        $display("test limit done");
        // each supply: refused start, then loss while running
        for (i = 0; i < 4; i++) begin
            ok4 = ~(4'h1 << i);
            want_main = 2'h1;
            cyc(3);
            chk(gate_drive_5v_slot_a, 0);
            want_main = 2'h0;
            ok4 = 4'hf;
            cyc(2);
            want_main = 2'h1;
            cyc(3);
            ok4 = ~(4'h1 << i);
            cyc(3);
            chk(fault_n_slot_a_oe, 1);
            chk(gate_drive_5v_slot_a, 0);
            ok4 = 4'hf;
            want_main = 2'h0;
            cyc(3);
            w1c(4'h1);
        end
        smbus_mode = 1'b1;
        want_main = 2'h3;
        cyc(3);
        chk(gate_drive_5v_slot_b, 0);
        $display("test supply done");
        // random address and general input levels
        for (i = 0; i < 8; i++) begin
            rnd = $random(seed);
            {addr_sel_2, addr_sel_1, addr_sel_0} = rnd[2:0];
            {gen_input_b, gen_input_a} = rnd[4:3];
            cyc(2);
            chk(smbus_base_addr, rnd[2:0]);
            chk(common_status, rnd[4:3]);
        end
        standby_supply_ok = 1'b0;
        cyc(2);
        chk(smbus_base_addr, ADDR_RST);
        chk(common_status, COMMON_RST);
        $display("test status done");
        report_and_stop;
    end
endmodule // dual_slot_power_fault_logic_tb
